/* rtl/msp_fifo.sv */
// synchronous fifo with a registered output stage.
// assumes DEPTH is a power of two; holds DEPTH words in memory plus one in the output stage.
`timescale 1ns/10ps
module msp_fifo #(
	parameter int WIDTH = msp_pkg::MSP_FIFO_WIDTH,
	parameter int DEPTH = msp_pkg::MSP_FIFO_DEPTH
) (
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_r;
	logic [AW-1:0]    rdPtr_r;
	logic [AW:0]      count_r;
	logic [AW:0]      count_nxt;
	logic             inReady_r;
	logic             outValid_r;
	logic [WIDTH-1:0] outData_r;

	wire push = inValid && inReady_r;
	wire load = (count_r != '0) && (!outValid_r || outReady);

	assign count_nxt = count_r + (AW+1)'(push) - (AW+1)'(load);
	assign inReady   = inReady_r;
	assign outValid  = outValid_r;
	assign outData   = outData_r;

	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wrPtr_r] <= inData;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			wrPtr_r    <= '0;
			rdPtr_r    <= '0;
			count_r    <= '0;
			inReady_r  <= 1'b0;
			outValid_r <= 1'b0;
			outData_r  <= '0;
		end else begin
			wrPtr_r   <= wrPtr_r + AW'(push);
			rdPtr_r   <= rdPtr_r + AW'(load);
			count_r   <= count_nxt;
			// registered ready: the source stalls as soon as memory is full
			inReady_r <= count_nxt < (AW+1)'(DEPTH);
			if (load) begin
				outValid_r <= 1'b1;
				outData_r  <= mem[rdPtr_r];
			end else if (outReady) begin
				outValid_r <= 1'b0;
			end
		end
	end
endmodule

/* rtl/msp_pkg.sv */
// constants and types shared by the mii/smii port and its transmit fifo.
// assumes a single core clock domain; all link pins are sampled, never used as clocks.
package msp_pkg;

	// port modes; gray along mii -> smii -> source-synchronous smii
	typedef enum logic [1:0] {
		MSP_MODE_MII    = 2'h0,
		MSP_MODE_SMII   = 2'h1,
		MSP_MODE_SMIISS = 2'h3
	} msp_mode_t;

	// figures of the link
	localparam int MSP_CORE_CLK_MHZ   = 100;
	localparam int MSP_REF_CLK_MHZ    = 125;
	localparam int MSP_MII_FAST_MHZ   = 25;
	localparam int MSP_SYNC_STAGES    = 2;

	// data path shape
	localparam int MSP_LANES          = 4;
	localparam int MSP_FIFO_DEPTH     = 16;
	localparam int MSP_FIFO_WIDTH     = MSP_LANES + 1;

	// reset values of the pins and captures
	localparam logic [3:0] MSP_NIBBLE_RST = 4'h0;
	localparam logic       MSP_TXEN_RST   = 1'b0;
	localparam logic [3:0] MSP_RXWORD_RST = 4'h0;

endpackage

/* rtl/msp_port.sv */
// one mac port pin stage: a 4-bit mii link or four smii serial lines.
// assumes link clocks are slow enough to be seen by core_clk after two flops;
// the user side is a nibble/word stream on core_clk.
//
// Contract
// - in mii mode the transmit nibble changes only on a rising edge of the phy transmit clock.
// - in smii modes transmit line n carries serial port n on the pin of nibble bit n.
// - serial data launches on the reference rising edge, or on the own clock output edge.
// - mii transmit enable rises with the first nibble and stays high to the frame's last nibble.
// - in source-synchronous smii the transmit enable pin carries the transmit clock out.
// - in source-synchronous smii receive data is sampled on the far end's receive clock.
// - the port performs no address hash filtering of its own.
`timescale 1ns/10ps
module msp_port #(
	parameter int LANES = msp_pkg::MSP_LANES,
	parameter int DEPTH = msp_pkg::MSP_FIFO_DEPTH
) (
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic [1:0]       cfgMode,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [LANES-1:0] inData,
	input  wire logic             inLast,
	input  wire logic             mii_tx_clock,
	output logic      [LANES-1:0] mii_tx_nibble,
	output logic                  mii_tx_valid,
	input  wire logic             mii_rx_clock,
	input  wire logic [LANES-1:0] rxLines,
	output logic      [LANES-1:0] rxWord,
	output logic                  rxWordValid
);
	localparam int SW = LANES + 2;

	msp_pkg::msp_mode_t mode;
	logic [SW-1:0]      sync1_r;
	logic [SW-1:0]      sync2_r;
	logic               txClkPrev_r;
	logic               rxClkPrev_r;
	logic               gap_r;
	logic [LANES-1:0]   nibble_r;
	logic               txEn_r;
	logic               txPin_r;
	logic [LANES-1:0]   rxWord_r;
	logic               rxWordValid_r;
	logic               fifoValid;
	logic [LANES:0]     fifoData;

	assign mode = (cfgMode == 2'h3) ? msp_pkg::MSP_MODE_SMIISS :
	              (cfgMode == 2'h1) ? msp_pkg::MSP_MODE_SMII : msp_pkg::MSP_MODE_MII;

	wire isMii    = (mode == msp_pkg::MSP_MODE_MII);
	wire isSrcSyn = (mode == msp_pkg::MSP_MODE_SMIISS);

	// only the second flop stage is read below
	wire txClkLvl = sync2_r[LANES+1];
	wire rxClkLvl = sync2_r[LANES];
	wire [LANES-1:0] rxLvl = sync2_r[LANES-1:0];

	wire txRise = txClkLvl && !txClkPrev_r;
	wire rxRise = rxClkLvl && !rxClkPrev_r;

	// in mii mode one idle nibble follows each last nibble so enable drops between frames
	wire txPop  = txRise && fifoValid && !(isMii && gap_r);
	wire wordLast = fifoData[LANES];
	// enable pin follows the enable register's next value so it leaves with its nibble
	wire txEnNext = txRise ? txPop : txEn_r;

	wire rxTake = isSrcSyn ? rxRise : (isMii ? rxRise : txRise);

	// no hash filter
	// received words pass unfiltered; address matching belongs upstream
	msp_fifo #(
		.WIDTH (LANES + 1),
		.DEPTH (DEPTH)
	) txFifo (
		.core_clk (core_clk),
		.rst      (rst),
		.inValid  (inValid),
		.inReady  (inReady),
		.inData   ({inLast, inData}),
		.outValid (fifoValid),
		.outReady (txPop),
		.outData  (fifoData)
	);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			sync1_r     <= '0;
			sync2_r     <= '0;
			txClkPrev_r <= 1'b0;
			rxClkPrev_r <= 1'b0;
		end else begin
			sync1_r     <= {mii_tx_clock, mii_rx_clock, rxLines};
			sync2_r     <= sync1_r;
			txClkPrev_r <= txClkLvl;
			rxClkPrev_r <= rxClkLvl;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			nibble_r <= msp_pkg::MSP_NIBBLE_RST;
			txEn_r   <= msp_pkg::MSP_TXEN_RST;
			gap_r    <= 1'b0;
		end else if (txRise) begin
			nibble_r <= txPop ? fifoData[LANES-1:0] : msp_pkg::MSP_NIBBLE_RST;
			txEn_r   <= txPop;
			gap_r    <= txPop && wordLast;
		end
	end

	// clock out on enable pin
	// the clock out follows the sampled reference, so data and its clock edge leave together
	always_ff @(posedge core_clk) begin
		if (rst) begin
			txPin_r <= msp_pkg::MSP_TXEN_RST;
		end else begin
			txPin_r <= isSrcSyn ? txClkLvl : (isMii ? txEnNext : 1'b0);
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rxWord_r      <= msp_pkg::MSP_RXWORD_RST;
			rxWordValid_r <= 1'b0;
		end else begin
			rxWordValid_r <= rxTake;
			if (rxTake) begin
				rxWord_r <= rxLvl;
			end
		end
	end

	assign mii_tx_nibble = nibble_r;
	assign mii_tx_valid  = txPin_r;
	assign rxWord        = rxWord_r;
	assign rxWordValid   = rxWordValid_r;
endmodule

/* tb/msp_phy_model.sv */
// far-end model: free link clocks, receive lines, nibble capture.
// assumes the port drives nibble and enable from its own clock.
`timescale 1ns/10ps
module msp_phy_model (
	output logic           txClk,
	output logic           rxClk,
	output logic     [3:0] rxLines,
	input wire logic [3:0] nibble,
	input wire logic       txEn
);
	logic [3:0] seen[$];
	initial begin
		txClk = 1'b0;
		forever #62.5 txClk = ~txClk;
	end
	// rx clock, lines change on its fall, away from any rise
	initial begin
		rxClk = 1'b0;
		rxLines = 4'h0;
		#60;
		forever begin
			#62.5 rxClk = ~rxClk;
			if (!rxClk) rxLines = rxLines + 4'h7;
		end
	end
	always @(posedge txClk) if (txEn) seen.push_back(nibble);
endmodule

/* tb/msp_port_monitor.sv */
// pin checker for msp_port, bound below.
// assumes link clocks near 125 ns, far below core_clk/2.
`timescale 1ns/10ps
module msp_port_monitor (
	input wire logic       core_clk,
	input wire logic       rst,
	input wire logic [1:0] cfgMode,
	input wire logic       mii_tx_clock,
	input wire logic [3:0] mii_tx_nibble,
	input wire logic       mii_tx_valid,
	input wire logic       mii_rx_clock,
	input wire logic [3:0] rxLines,
	input wire logic [3:0] rxWord,
	input wire logic       rxWordValid
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	a_reset_quiet: assert property (disable iff (1'b0) rst |=> mii_tx_nibble == 4'h0 && !mii_tx_valid && !rxWordValid) else $error("pins not quiet in reset");
	a_rx_single: assert property (rxWordValid |=> !rxWordValid) else $error("rx pulse too long");
	a_rx_word: assert property (rxWordValid |-> rxWord == $past(rxLines, 3)) else $error("rx word wrong");
	a_rx_cause: assert property (rxWordValid && cfgMode != 2'h1 && cfgMode == $past(cfgMode, 8) |-> $past(mii_rx_clock, 3) && !$past(mii_rx_clock, 7)) else $error("rx capture off clock");
	a_smii_txen_low: assert property (cfgMode == 2'h1 && $past(cfgMode) == 2'h1 |-> !mii_tx_valid) else $error("enable pin active in smii");
	a_ss_clock_out: assert property ($rose(mii_tx_clock) && cfgMode == 2'h3 |-> ##[2:4] mii_tx_valid) else $error("clock out missing");
	a_nibble_timing: assert property (!$stable(mii_tx_nibble) && cfgMode == $past(cfgMode, 8) |-> $past(mii_tx_clock, 2) && !$past(mii_tx_clock, 6)) else $error("nibble off tx edge");
	a_txen_timing: assert property (!$stable(mii_tx_valid) && cfgMode == 2'h0 && $past(cfgMode, 8) == 2'h0 |-> $past(mii_tx_clock, 2) && !$past(mii_tx_clock, 7)) else $error("enable off tx edge");
	c_rx: cover property (rxWordValid);
	c_frame_end: cover property (cfgMode == 2'h0 && $fell(mii_tx_valid));
	c_ss_clock: cover property (cfgMode == 2'h3 && $rose(mii_tx_valid));
endmodule

bind msp_port msp_port_monitor msp_port_monitor_inst (.core_clk(core_clk), .rst(rst),
	.cfgMode(cfgMode), .mii_tx_clock(mii_tx_clock), .mii_tx_nibble(mii_tx_nibble),
	.mii_tx_valid(mii_tx_valid), .mii_rx_clock(mii_rx_clock), .rxLines(rxLines),
	.rxWord(rxWord), .rxWordValid(rxWordValid));

/* tb/tb_top.sv */
// self-checking bench for msp_port with the far-end model.
// assumes the checker binds itself.
`timescale 1ns/10ps
module tb_top;
	logic       core_clk, rst, inValid, inLast, inReady, txClk, rxClk, txValid, rxWordValid;
	logic [1:0] cfgMode;
	logic [3:0] inData, rxLines, nibble, rxWord;
	int         failures, checks_done, cyc, n, k;
	msp_port msp_port_inst (.core_clk(core_clk), .rst(rst), .cfgMode(cfgMode),
		.inValid(inValid), .inReady(inReady), .inData(inData), .inLast(inLast),
		.mii_tx_clock(txClk), .mii_tx_nibble(nibble), .mii_tx_valid(txValid),
		.mii_rx_clock(rxClk), .rxLines(rxLines), .rxWord(rxWord), .rxWordValid(rxWordValid));
	msp_phy_model msp_phy_model_inst (.txClk(txClk), .rxClk(rxClk), .rxLines(rxLines),
		.nibble(nibble), .txEn(txValid));
	task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	task close_out;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// called at an edge; leaves valid up so back-to-back words need no gap
	task push(input logic [3:0] d, input logic l);
		inValid <= 1'b1;
		inData <= d;
		inLast <= l;
		do @(posedge core_clk); while (inReady !== 1'b1);
	endtask
	task mode(input logic [1:0] m);
		cfgMode <= m;
		repeat (10) @(posedge core_clk);
	endtask
	task t_mii;
		for (int i = 1; i <= 5; i++) push(4'(i), i == 5);
		inValid <= 1'b0;
		repeat (100) @(posedge core_clk);
		chk("frame size", 8'h5, 8'(msp_phy_model_inst.seen.size()));
		for (int i = 0; i < 5; i++) chk("frame nibble", 8'(i + 1), 8'(msp_phy_model_inst.seen[i]));
	endtask
	task t_fill;
		mode(2'h1);
		n = 0;
		inValid <= 1'b1;
		inData <= 4'h0;
		repeat (40) @(posedge core_clk) if (inReady) n++;
		inValid <= 1'b0;
		chk("taken words", 8'h1, 8'(n >= 17 && n <= 21));
		repeat (300) @(posedge core_clk);
		chk("drained ready", 8'h1, 8'(inReady));
	endtask
	task t_lanes;
		for (int i = 0; i < 2; i++) begin
			mode(i ? 2'h3 : 2'h1);
			push(i ? 4'h5 : 4'hA, 1'b0);
			inValid <= 1'b0;
			k = 0;
			while (nibble !== (i ? 4'h5 : 4'hA) && k < 40) begin
				@(posedge core_clk);
				k++;
			end
			chk("serial lanes", 8'(i ? 4'h5 : 4'hA), 8'(nibble));
		end
	endtask
	task t_clock_out;
		logic prev;
		n = 0;
		prev = txValid;
		repeat (100) begin
			@(posedge core_clk);
			if (txValid && !prev) n++;
			prev = txValid;
		end
		chk("clock out rises", 8'h1, 8'(n >= 7 && n <= 9));
	endtask
	task t_rx;
		for (int i = 0; i < 3; i++) begin
			mode(i == 2 ? 2'h3 : 2'(i));
			k = 0;
			do @(posedge core_clk); while (rxWordValid !== 1'b1 && ++k < 40);
			chk("rx word", 8'(rxLines), 8'(rxWord));
		end
	endtask
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			close_out();
		end
	end
	initial begin
		rst = 1'b1;
		cfgMode = 2'h0;
		inValid = 1'b0;
		inData = 4'h0;
		inLast = 1'b0;
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		#1;
		chk("reset pins", 8'h0, {3'h0, txValid, nibble});
		@(posedge core_clk);
		t_mii();
		t_fill();
		t_lanes();
		t_clock_out();
		t_rx();
		close_out();
	end
endmodule
